// File: logic/crac_pkg.sv
// shared types and constants for the cell register clear/preset control
`default_nettype none
package crac_pkg;

    // =====================================================================
    // static mode of the clear and preset logic
    typedef enum logic [2:0] {
        CRAC_MODE_CLR_ONLY,
        CRAC_MODE_PRE_ONLY,
        CRAC_MODE_CLR_PRE,
        CRAC_MODE_LOAD_CLR,
        CRAC_MODE_LOAD_PRE,
        CRAC_MODE_LOAD_ONLY
    } crac_mode_t;

    // which block control line a single-line function listens to
    localparam logic CRAC_SEL_CTRL_A = 1'b0;
    localparam logic CRAC_SEL_CTRL_B = 1'b1;

    // =====================================================================
    // register values
    localparam logic CRAC_PHYS_RESET = 1'b0;
    localparam logic CRAC_PHYS_CLEAR = 1'b0;
    localparam logic CRAC_PHYS_PRESET = 1'b1;
    localparam logic CRAC_TIED_HIGH = 1'b1;
    localparam logic CRAC_PIN_INACTIVE = 1'b1;
    localparam logic [3:0] CRAC_STATUS_RESET = 4'h0;

    // =====================================================================
    // configuration, fixed while the cell runs
    typedef struct packed {
        crac_mode_t mode;
        logic clrSel;
        logic preSel;
        logic preByInvert;
        logic rstEnable;
    } crac_cfg_t;

    // registered view of what the asynchronous controls are doing
    typedef struct packed {
        logic clrActive;
        logic preActive;
        logic loadDataUsed;
        logic inverted;
    } crac_status_t;

endpackage
`default_nettype wire

// File: logic/crac_reg_core.sv
// physical cell flip-flop with active-low clear and preset and a clock enable
`timescale 1ns/1ps
`default_nettype none
module crac_reg_core
    import crac_pkg::*;
(
    input wire logic mclk,
    input wire logic chipRst,
    input wire logic clrN,
    input wire logic preN,
    input wire logic clkEnable,
    input wire logic d,
    output logic q
);

    logic next_q;
    logic preGateN;

    // =====================================================================
    // synchronous path
    always_comb
    begin
        next_q = q;
        if (clkEnable)
        begin
            next_q = d;
        end
    end

    // =====================================================================
    // storage
    // reset beats clear beats preset; preset is only let through while clear
    // and reset are off, so a preset still held when they let go falls here
    // and takes effect at once instead of waiting for the next clock
    assign preGateN = preN | ~clrN | chipRst;

    always_ff @(posedge mclk or posedge chipRst or negedge clrN or negedge preGateN)
    begin
        if (chipRst)
        begin
            q <= CRAC_PHYS_RESET;
        end
        else if (!clrN)
        begin
            q <= CRAC_PHYS_CLEAR;
        end
        else if (!preGateN)
        begin
            q <= CRAC_PHYS_PRESET;
        end
        else
        begin
            q <= next_q;
        end
    end

endmodule
`default_nettype wire

// File: logic/crac_cell_register.sv
// logic cell register with six-mode asynchronous clear, preset and load control
//
// How it works
// - clear/preset come only from three inputs
// - either control line may drive the clear
// - load mode: line A forces data asynchronously
// - clear and preset active low, unused held high
// - six static modes fixed by configuration
// - enabled chip reset overrides every mode
// - preset-built registers may read one after reset
// - clear-only: preset inactive, selected line clears
// - preset-only as load of constant high
// - preset via inverted clear frees load data
// - clear-and-preset: A presets, B clears
// - load-with-clear: A loads, B clears only
// - load-with-preset: inverted register, data inverted
// - load-only: A drives preset and clear from data
// - synchronous clock enable in every mode
`timescale 1ns/1ps
`default_nettype none
module crac_cell_register
    import crac_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire crac_cfg_t cfg,
    input wire logic loadDataIn,
    input wire logic blockCtrlA,
    input wire logic blockCtrlB,
    input wire logic syncData,
    input wire logic clkEnable,
    output logic cellOut,
    output logic asyncClrN,
    output logic asyncPreN,
    output crac_status_t status
);

    // =====================================================================
    // helpers

    // picks one of the two block control lines
    function automatic logic pickCtrl(input logic sel, input logic a, input logic b);
        begin
            if (sel == CRAC_SEL_CTRL_B)
            begin
                pickCtrl = b;
            end
            else
            begin
                pickCtrl = a;
            end
        end
    endfunction

    // true for modes that steer preset and clear from the load data
    function automatic logic modeLoads(input crac_mode_t mode);
        begin
            modeLoads = (mode == CRAC_MODE_LOAD_CLR) ||
                        (mode == CRAC_MODE_LOAD_PRE) ||
                        (mode == CRAC_MODE_LOAD_ONLY);
        end
    endfunction

    // =====================================================================
    // signals

    logic invert;
    logic loadDataUsed;
    logic loadBit;
    logic clrReq;
    logic preReq;
    logic chipRst;
    logic physD;
    logic physQ;
    crac_status_t next_status;

    // =====================================================================
    // mode decode
    // only the load data and the two control lines reach the async pins
    always_comb
    begin
        invert = 1'b0;
        loadDataUsed = 1'b0;
        loadBit = CRAC_TIED_HIGH;
        clrReq = 1'b0;
        preReq = 1'b0;
        case (cfg.mode)
            CRAC_MODE_CLR_ONLY:
            begin
                // preset stays released
                clrReq = pickCtrl(cfg.clrSel, blockCtrlA, blockCtrlB);
                preReq = 1'b0;
            end
            CRAC_MODE_PRE_ONLY:
            begin
                if (cfg.preByInvert)
                begin
                    // clearing the inverted flop reads back as one
                    invert = 1'b1;
                    clrReq = pickCtrl(cfg.preSel, blockCtrlA, blockCtrlB);
                    loadDataUsed = 1'b0;
                end
                else
                begin
                    // load of a constant high
                    loadBit = CRAC_TIED_HIGH;
                    preReq = blockCtrlA & loadBit;
                    clrReq = blockCtrlA & ~loadBit;
                end
            end
            CRAC_MODE_CLR_PRE:
            begin
                loadBit = CRAC_TIED_HIGH;
                preReq = blockCtrlA & loadBit;
                clrReq = (blockCtrlA & ~loadBit) | blockCtrlB;
            end
            CRAC_MODE_LOAD_CLR:
            begin
                loadDataUsed = 1'b1;
                loadBit = loadDataIn;
                preReq = blockCtrlA & loadBit;
                clrReq = (blockCtrlA & ~loadBit) | blockCtrlB;
            end
            CRAC_MODE_LOAD_PRE:
            begin
                // the flop holds the complement, so the load value is
                // complemented on the way in and B clears to a logical one
                invert = 1'b1;
                loadDataUsed = 1'b1;
                loadBit = ~loadDataIn;
                preReq = blockCtrlA & loadBit;
                clrReq = (blockCtrlA & ~loadBit) | blockCtrlB;
            end
            CRAC_MODE_LOAD_ONLY:
            begin
                loadDataUsed = 1'b1;
                loadBit = loadDataIn;
                preReq = blockCtrlA & loadBit;
                clrReq = blockCtrlA & ~loadBit;
            end
            default:
            begin
                // unknown codes leave both pins released
                clrReq = 1'b0;
                preReq = 1'b0;
            end
        endcase
    end

    // =====================================================================
    // pin drive
    // released pins sit high
    always_comb
    begin
        asyncClrN = CRAC_PIN_INACTIVE;
        asyncPreN = CRAC_PIN_INACTIVE;
        if (clrReq)
        begin
            asyncClrN = ~CRAC_PIN_INACTIVE;
        end
        if (preReq)
        begin
            asyncPreN = ~CRAC_PIN_INACTIVE;
        end
    end

    // chip reset only reaches the flop when enabled
    assign chipRst = rst & cfg.rstEnable;

    // =====================================================================
    // synchronous data path
    // the input inversion matches the output inversion, so clocked data
    // looks the same in every mode
    assign physD = syncData ^ invert;

    crac_reg_core u_core (
        .mclk(mclk),
        .chipRst(chipRst),
        .clrN(asyncClrN),
        .preN(asyncPreN),
        .clkEnable(clkEnable),
        .d(physD),
        .q(physQ)
    );

    // reset clears the physical flop; an inverted cell therefore shows one
    assign cellOut = physQ ^ invert;

    // =====================================================================
    // status
    always_comb
    begin
        next_status.clrActive = ~asyncClrN;
        next_status.preActive = ~asyncPreN & asyncClrN;
        next_status.loadDataUsed = loadDataUsed & modeLoads(cfg.mode);
        next_status.inverted = invert;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            status <= CRAC_STATUS_RESET;
        end
        else
        begin
            status <= next_status;
        end
    end

endmodule
`default_nettype wire

// File: sim/crac_block_model.sv
// surrounding logic block model driving the cell's control and data lines
`timescale 1ns/1ps
`default_nettype none
module crac_block_model (
    input wire logic mclk,
    input wire logic [4:0] req,
    output logic blockCtrlA,
    output logic blockCtrlB,
    output logic loadDataIn,
    output logic syncData,
    output logic clkEnable
);
    initial
    begin
        {blockCtrlA, blockCtrlB, loadDataIn, syncData, clkEnable} = 5'h00;
    end
    // routed lines move only between rising edges, never at the sampling edge
    always @(negedge mclk)
    begin
        {blockCtrlA, blockCtrlB, loadDataIn, syncData, clkEnable} <= req;
    end
endmodule
`default_nettype wire

// File: sim/crac_cell_register_props.sv
// assertions on the ports of the cell register clear/preset control
`timescale 1ns/1ps
`default_nettype none
module crac_cell_register_props
    import crac_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire crac_cfg_t cfg,
    input wire logic loadDataIn,
    input wire logic blockCtrlA,
    input wire logic blockCtrlB,
    input wire logic syncData,
    input wire logic clkEnable,
    input wire logic cellOut,
    input wire logic asyncClrN,
    input wire logic asyncPreN,
    input wire crac_status_t status
);
    // =========================================
    // checks
    crac_mode_t md;
    logic inv;
    logic idle;
    logic ld;
    assign md = cfg.mode;
    assign ld = md == CRAC_MODE_LOAD_CLR || md == CRAC_MODE_LOAD_PRE || md == CRAC_MODE_LOAD_ONLY;
    assign inv = md == CRAC_MODE_LOAD_PRE || (md == CRAC_MODE_PRE_ONLY && cfg.preByInvert);
    assign idle = asyncClrN && asyncPreN;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_rst_wins: assert property (disable iff (1'b0) rst && cfg.rstEnable |-> cellOut == inv)
        else $error("reset value wrong");
    a_clr_only_pre: assert property (md == CRAC_MODE_CLR_ONLY |-> asyncPreN)
        else $error("preset not idle");
    a_clr_sel: assert property (md == CRAC_MODE_CLR_ONLY |->
        asyncClrN == !(cfg.clrSel ? blockCtrlB : blockCtrlA)) else $error("clear line wrong");
    a_load_only: assert property (md == CRAC_MODE_LOAD_ONLY && blockCtrlA |-> cellOut == loadDataIn)
        else $error("load wrong");
    a_clr_pre: assert property (md == CRAC_MODE_CLR_PRE && (blockCtrlA || blockCtrlB) |-> cellOut == !blockCtrlB)
        else $error("clear/preset wrong");
    a_load_clr: assert property (md == CRAC_MODE_LOAD_CLR && (blockCtrlA || blockCtrlB) |->
        cellOut == (!blockCtrlB && loadDataIn)) else $error("load clear wrong");
    a_load_pre: assert property (md == CRAC_MODE_LOAD_PRE && (blockCtrlA || blockCtrlB) |->
        cellOut == (blockCtrlB || loadDataIn)) else $error("load preset wrong");
    a_pre_only: assert property (md == CRAC_MODE_PRE_ONLY && !cfg.preByInvert && blockCtrlA |-> cellOut)
        else $error("preset wrong");
    a_hold_off: assert property (!clkEnable && idle ##1 idle |-> $stable(cellOut))
        else $error("disabled edge changed output");
    a_clk_load: assert property (clkEnable && idle ##1 idle |-> cellOut == $past(syncData))
        else $error("enabled edge missed data");
    a_status_ctl: assert property (!$past(rst) |->
        status.clrActive == $past(!asyncClrN) && status.preActive == $past(!asyncPreN && asyncClrN))
        else $error("status controls wrong");
    a_status_mode: assert property (!$past(rst) |->
        status.inverted == inv && status.loadDataUsed == ld) else $error("status mode wrong");
    c_load: cover property (md == CRAC_MODE_LOAD_ONLY && blockCtrlA);
    c_both: cover property (md == CRAC_MODE_CLR_PRE && blockCtrlA && blockCtrlB);
    c_clk: cover property (clkEnable && idle);
    c_load_pre: cover property (md == CRAC_MODE_LOAD_PRE && blockCtrlB);
endmodule
`default_nettype wire

// File: sim/crac_cell_register_tb_top.sv
// self-checking bench for the cell register clear/preset control
`timescale 1ns/1ps
`default_nettype none
module crac_cell_register_tb_top;
    import crac_pkg::*;
    logic mclk;
    logic rst;
    crac_cfg_t cfg;
    logic [4:0] req;
    logic blockCtrlA, blockCtrlB, loadDataIn, syncData, clkEnable;
    logic cellOut, asyncClrN, asyncPreN;
    crac_status_t status;
    logic p;
    logic iv;
    int n_fail;
    int checked;
    crac_block_model i_crac_block_model (.mclk(mclk), .req(req), .blockCtrlA(blockCtrlA),
        .blockCtrlB(blockCtrlB), .loadDataIn(loadDataIn), .syncData(syncData),
        .clkEnable(clkEnable));
    crac_cell_register i_crac_cell_register (.mclk(mclk), .rst(rst), .cfg(cfg),
        .loadDataIn(loadDataIn), .blockCtrlA(blockCtrlA), .blockCtrlB(blockCtrlB),
        .syncData(syncData), .clkEnable(clkEnable), .cellOut(cellOut),
        .asyncClrN(asyncClrN), .asyncPreN(asyncPreN), .status(status));
    // =========================================
    // expectation: {forced, logical value}
    function automatic logic [1:0] fv(input logic [4:0] r);
        logic a;
        logic b;
        a = r[4];
        b = r[3];
        case (cfg.mode)
            CRAC_MODE_CLR_ONLY: return {cfg.clrSel ? b : a, 1'b0};
            CRAC_MODE_PRE_ONLY: return {cfg.preByInvert && cfg.preSel ? b : a, 1'b1};
            CRAC_MODE_CLR_PRE: return {a | b, !b};
            CRAC_MODE_LOAD_CLR: return {a | b, !b & r[2]};
            CRAC_MODE_LOAD_PRE: return {a | b, b | r[2]};
            default: return {a, r[2]};
        endcase
    endfunction
    task automatic chk(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask
    // p is the physical flop; an enabled edge only counts with no async control
    task automatic st(input logic [4:0] r);
        logic [1:0] f;
        @(posedge mclk);
        f = fv(req);
        if (!f[1] && req[0])
            p = req[1] ^ iv;
        req = r;
        @(negedge mclk);
        #1;
        f = fv(r);
        if (f[1])
            p = f[0] ^ iv;
        chk("cellOut", p ^ iv, cellOut);
        chk("inverted", iv, status.inverted);
    endtask
    task automatic rs(input crac_cfg_t c);
        st(5'h00);
        @(negedge mclk);
        rst = 1'b1;
        cfg = c;
        iv = c.mode == CRAC_MODE_LOAD_PRE || (c.mode == CRAC_MODE_PRE_ONLY && c.preByInvert);
        #1;
        if (c.rstEnable)
            p = 1'b0;
        chk("reset", p ^ iv, cellOut);
        @(negedge mclk);
        rst = 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        #100000;
        n_fail++;
        close_out();
    end
    initial
    begin
        rst = 1'b1;
        cfg = '{CRAC_MODE_CLR_ONLY, 1'b0, 1'b0, 1'b0, 1'b1};
        req = 5'h00;
        p = 1'b0;
        iv = 1'b0;
        n_fail = 0;
        checked = 0;
        void'($urandom(88));
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        for (int m = 0; m < 6; m++)
        begin
            for (int v = 0; v < 2; v++)
            begin
                rs('{crac_mode_t'(m), v[0], v[0], v[0], ~v[0] | m[0]});
                st(5'h1c);
                st(5'h00);
                repeat (12)
                begin
                    st(5'($urandom));
                    st({2'b00, 3'($urandom)});
                end
                $display("test mode %0d variant %0d done", m, v);
            end
        end
        close_out();
    end
endmodule
bind crac_cell_register crac_cell_register_props i_crac_cell_register_props (.mclk(mclk),
    .rst(rst), .cfg(cfg), .loadDataIn(loadDataIn), .blockCtrlA(blockCtrlA),
    .blockCtrlB(blockCtrlB), .syncData(syncData), .clkEnable(clkEnable), .cellOut(cellOut),
    .asyncClrN(asyncClrN), .asyncPreN(asyncPreN), .status(status));
`default_nettype wire
